// File: rtl/dspfs_pkg.sv
// Package: constants and carriers for the decoder/SPI pin function select block
package dspfs_pkg;

   // Pin functions of the two decoder pins
   typedef enum logic [1:0] {DSPFS_QUAD, DSPFS_TIMER, DSPFS_PORT} dspfs_qfunc_e;
   // Pin functions of the four SPI pins
   typedef enum logic [0:0] {DSPFS_SPI, DSPFS_GPIO} dspfs_sfunc_e;

   // Pull-up bit positions in the port pull-up registers
   localparam int unsigned PC_INDEX_BIT   = 6;
   localparam int unsigned PC_HOME_BIT    = 7;
   localparam int unsigned PE_SCLK_BIT    = 4;
   localparam int unsigned PE_MOSI_BIT    = 5;
   localparam int unsigned PE_MISO_BIT    = 6;
   localparam int unsigned PE_SS_BIT      = 7;
   // Reset values: every pull-up on
   localparam logic [7:0]  PULLUP_RST     = 8'hff;
   localparam logic [1:0]  QFUNC_RST      = 2'h0;
   localparam logic [3:0]  SFUNC_RST      = 4'h0;
   localparam logic [3:0]  GPIO_DIR_RST   = 4'h0;

   // Drive triple for one pad: out, enable (active low), pull-up
   typedef struct packed {
      logic o;
      logic oe_n;
      logic pu;
   } dspfs_pad_s;

endpackage : dspfs_pkg

// File: rtl/dspfs_top.sv
// Pin function select and pull-up control for the decoder and SPI 0 pins
// Notes on behaviour
// - After reset pin 0 carries the decoder index input; timer channel 2 and port C line 6 are alternates.
// - Bit 6 of the port C pull-up register controls the index pin pull-up, cleared means off.
// - After reset pin 1 carries the decoder home input; timer channel 3 and port C line 7 are alternates.
// - Bit 7 of the port C pull-up register controls the home pin pull-up, cleared means off.
// - The SPI clock pin is driven out in master mode and is the clock input in slave mode.
// - Bit 4 of the port E pull-up register controls the SPI clock pull-up, cleared means off.
// - Out of reset all four SPI pins take their SPI functions, not port E lines 4 to 7.
// - The master presents each out bit half a clock early; the slave takes that line as input.
// - Bit 5 of the port E pull-up register controls the master-out pull-up, cleared means off.
// - A slave that is not selected leaves its master-in output undriven.
// - A selected slave drives each master-in bit half a clock before the master latches it.
// - Bit 6 of the port E pull-up register controls the master-in pull-up, cleared means off.
// - In slave mode the slave-select input marks a transfer as addressed to this device.
// - Bit 7 of the port E pull-up register controls the slave-select pull-up, cleared means off.
// - A pin given to its port function has its own software-set direction.
`timescale 1ns/1ps

module dspfs_top
(
   input  wire logic        i_clk,            // 200 MHz clock
   input  wire logic        i_rst_n,          // Async reset, active low
   // Software configuration
   input  wire logic [1:0]  i_idx_func,       // Index pin function select
   input  wire logic [1:0]  i_home_func,      // Home pin function select
   input  wire logic [3:0]  i_spi_gpio,       // 1: SPI pin to port E line
   input  wire logic        i_pc_pu_we,       // Port C pull-up write strobe
   input  wire logic [7:0]  i_pc_pu_wdata,    // Port C pull-up write data
   input  wire logic        i_pe_pu_we,       // Port E pull-up write strobe
   input  wire logic [7:0]  i_pe_pu_wdata,    // Port E pull-up write data
   input  wire logic [5:0]  i_gpio_dir,       // Port direction per pin, 1 out
   input  wire logic [5:0]  i_gpio_out,       // Port output data per pin
   // Peripheral side
   input  wire logic [1:0]  i_timer_out,      // Timer A ch2/ch3 outputs
   input  wire logic [1:0]  i_timer_oe,       // Timer A ch2/ch3 drive enables
   input  wire logic        i_spi_master,     // SPI 0 in master mode
   input  wire logic        i_spi_sclk_out,   // Master clock from SPI 0
   input  wire logic        i_spi_mosi_out,   // Master data from SPI 0
   input  wire logic        i_spi_miso_out,   // Slave data from SPI 0
   // Pads in
   input  wire logic [5:0]  i_pad,            // Pad levels: idx,home,sclk,mosi,miso,ss
   // Pads out
   output logic      [5:0]  o_pad,            // Pad output levels
   output logic      [5:0]  o_pad_oe_n,       // Pad drive enable, low drives
   output logic      [5:0]  o_pad_pu,         // Pad pull-up enables
   // Peripheral inputs
   output logic             o_quad0_index_in, // Decoder index input
   output logic             o_quad0_home_in,  // Decoder home input
   output logic      [1:0]  o_timer_in,       // Timer A ch2/ch3 inputs
   output logic             o_spi_sclk_in,    // Slave clock into SPI 0
   output logic             o_spi_mosi_in,    // Slave data into SPI 0
   output logic             o_spi_miso_in,    // Master data into SPI 0
   output logic             o_spi_selected,   // Slave addressed (select low)
   output logic      [5:0]  o_gpio_in,        // Port input levels per pin
   output logic      [7:0]  o_port_c_pullup_reg, // Port C pull-up register
   output logic      [7:0]  o_port_e_pullup_reg  // Port E pull-up register
);

   // Select decode, shared by both decoder pins
   function automatic dspfs_pkg::dspfs_qfunc_e qsel(input logic [1:0] v);
      case (v)
         2'h1:    qsel = dspfs_pkg::DSPFS_TIMER;
         2'h2:    qsel = dspfs_pkg::DSPFS_PORT;
         default: qsel = dspfs_pkg::DSPFS_QUAD;
      endcase
   endfunction : qsel

   // Configuration state
   logic [7:0] pc_pu;
   logic [7:0] pe_pu;
   logic [7:0] next_pc_pu;
   logic [7:0] next_pe_pu;
   dspfs_pkg::dspfs_qfunc_e qf [2];
   dspfs_pkg::dspfs_qfunc_e next_qf [2];
   logic [3:0] sf;
   logic [3:0] next_sf;

   // Register writes; unmapped select code falls back to decoder function
   always_comb
   begin
      next_pc_pu = i_pc_pu_we ? i_pc_pu_wdata : pc_pu;
      next_pe_pu = i_pe_pu_we ? i_pe_pu_wdata : pe_pu;
      next_qf[0] = qsel(i_idx_func);
      next_qf[1] = qsel(i_home_func);
      next_sf    = i_spi_gpio;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         pc_pu <= dspfs_pkg::PULLUP_RST;
         pe_pu <= dspfs_pkg::PULLUP_RST;
         qf[0] <= dspfs_pkg::DSPFS_QUAD;
         qf[1] <= dspfs_pkg::DSPFS_QUAD;
         sf    <= dspfs_pkg::SFUNC_RST;
      end
      else
      begin
         pc_pu <= next_pc_pu;
         pe_pu <= next_pe_pu;
         qf    <= next_qf;
         sf    <= next_sf;
      end
   end

   // Per-pad drive computed combinationally, then registered
   dspfs_pkg::dspfs_pad_s next_pad [6];
   logic [5:0]            pu_map;
   logic                  sel_n;

   // Pull-up bit per pad
   always_comb
   begin
      pu_map[0] = pc_pu[dspfs_pkg::PC_INDEX_BIT];
      pu_map[1] = pc_pu[dspfs_pkg::PC_HOME_BIT];
      pu_map[2] = pe_pu[dspfs_pkg::PE_SCLK_BIT];
      pu_map[3] = pe_pu[dspfs_pkg::PE_MOSI_BIT];
      pu_map[4] = pe_pu[dspfs_pkg::PE_MISO_BIT];
      pu_map[5] = pe_pu[dspfs_pkg::PE_SS_BIT];
      sel_n     = i_pad[5];
   end

   // Decoder pins: quad input only, timer per its drive enable, port per direction
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_qpin
         always_comb
         begin
            next_pad[g].pu = pu_map[g];
            case (qf[g])
               dspfs_pkg::DSPFS_TIMER:
               begin
                  next_pad[g].o    = i_timer_out[g];
                  next_pad[g].oe_n = ~i_timer_oe[g];
               end
               dspfs_pkg::DSPFS_PORT:
               begin
                  next_pad[g].o    = i_gpio_out[g];
                  next_pad[g].oe_n = ~i_gpio_dir[g];
               end
               default:
               begin
                  next_pad[g].o    = 1'b0;
                  next_pad[g].oe_n = 1'b1;
               end
            endcase
         end
      end
   endgenerate

   // SPI pins: directions follow master/slave mode and selection
   generate
      for (g = 2; g < 6; g++)
      begin : g_spin
         always_comb
         begin
            next_pad[g].pu   = pu_map[g];
            next_pad[g].o    = 1'b0;
            next_pad[g].oe_n = 1'b1;
            if (sf[g-2])
            begin
               next_pad[g].o    = i_gpio_out[g];
               next_pad[g].oe_n = ~i_gpio_dir[g];
            end
            else if (g == 2)
            begin
               next_pad[g].o    = i_spi_sclk_out;
               next_pad[g].oe_n = ~i_spi_master;
            end
            else if (g == 3)
            begin
               // SPI core shifts on the opposite edge; pad just follows
               next_pad[g].o    = i_spi_mosi_out;
               next_pad[g].oe_n = ~i_spi_master;
            end
            else if (g == 4)
            begin
               next_pad[g].o    = i_spi_miso_out;
               // Undriven unless slave and selected; avoids bus fights
               next_pad[g].oe_n = i_spi_master | sel_n;
            end
         end
      end
   endgenerate

   // Pad drive flattened from the per-pad structs
   logic [5:0] next_pad_o;
   logic [5:0] next_pad_oe_n;
   logic [5:0] next_pad_pu;

   // Peripheral input values; a decoder, timer or SPI data/clock input not selected reads idle high, port inputs always see the pad
   logic [1:0] next_quad_in;
   logic [1:0] next_timer_in;
   logic       next_spi_sclk_in;
   logic       next_spi_mosi_in;
   logic       next_spi_miso_in;
   logic       next_spi_selected;
   logic [5:0] next_gpio_in;

   // Route pad levels to the peripherals that own each pin
   always_comb
   begin
      next_quad_in  = 2'h3;
      next_timer_in = 2'h3;
      next_gpio_in  = i_pad;
      // Pad triples to flat vectors
      for (int k = 0; k < 6; k++)
      begin
         next_pad_o[k]    = next_pad[k].o;
         next_pad_oe_n[k] = next_pad[k].oe_n;
         next_pad_pu[k]   = next_pad[k].pu;
      end
      // Decoder pins: only the selected decoder or timer function sees the pad; the port input always does
      for (int k = 0; k < 2; k++)
      begin
         case (qf[k])
            dspfs_pkg::DSPFS_TIMER:
            begin
               next_timer_in[k] = i_pad[k];
            end
            dspfs_pkg::DSPFS_PORT:
            begin
               // Port function: level only reaches the port input
               next_timer_in[k] = 1'b1;
            end
            default:
            begin
               next_quad_in[k] = i_pad[k];
            end
         endcase
      end
      // SPI pins: a pin handed to port E hides its level from SPI 0
      if (!sf[0])
      begin
         next_spi_sclk_in = i_pad[2];
      end
      else
      begin
         next_spi_sclk_in = 1'b1;
      end
      if (!sf[1])
      begin
         next_spi_mosi_in = i_pad[3];
      end
      else
      begin
         next_spi_mosi_in = 1'b1;
      end
      if (!sf[2])
      begin
         next_spi_miso_in = i_pad[4];
      end
      else
      begin
         next_spi_miso_in = 1'b1;
      end
      // Select counts only in slave mode; a master ignores the pin
      if (!sf[3] && !i_spi_master)
      begin
         next_spi_selected = ~sel_n;
      end
      else
      begin
         next_spi_selected = 1'b0;
      end
   end

   // Register pad and peripheral outputs
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pad               <= 6'h00;
         o_pad_oe_n          <= 6'h3f;
         o_pad_pu            <= 6'h3f;
         o_quad0_index_in    <= 1'b1;
         o_quad0_home_in     <= 1'b1;
         o_timer_in          <= 2'h3;
         o_spi_sclk_in       <= 1'b1;
         o_spi_mosi_in       <= 1'b1;
         o_spi_miso_in       <= 1'b1;
         o_spi_selected      <= 1'b0;
         o_gpio_in           <= 6'h3f;
         o_port_c_pullup_reg <= dspfs_pkg::PULLUP_RST;
         o_port_e_pullup_reg <= dspfs_pkg::PULLUP_RST;
      end
      else
      begin
         o_pad               <= next_pad_o;
         o_pad_oe_n          <= next_pad_oe_n;
         o_pad_pu            <= next_pad_pu;
         o_quad0_index_in    <= next_quad_in[0];
         o_quad0_home_in     <= next_quad_in[1];
         o_timer_in          <= next_timer_in;
         o_spi_sclk_in       <= next_spi_sclk_in;
         o_spi_mosi_in       <= next_spi_mosi_in;
         o_spi_miso_in       <= next_spi_miso_in;
         o_spi_selected      <= next_spi_selected;
         o_gpio_in           <= next_gpio_in;
         o_port_c_pullup_reg <= pc_pu;
         o_port_e_pullup_reg <= pe_pu;
      end
   end

endmodule : dspfs_top

// File: testbench/dspfs_asserts.sv
// Checker: timing relations at the pins of the function select block
`timescale 1ns/1ps
module dspfs_asserts
(
   input wire logic       i_clk, i_rst_n, i_pc_pu_we, i_spi_master, // Clock, strobe, mode
   input wire logic       i_spi_sclk_out, i_spi_mosi_out, o_spi_selected, // SPI bits
   input wire logic [1:0] i_home_func, i_idx_func, i_timer_oe, o_timer_in, // Timer side
   input wire logic [3:0] i_spi_gpio, // SPI pin to port
   input wire logic [5:0] i_gpio_dir, i_gpio_out, i_pad, o_pad, o_pad_oe_n, o_pad_pu, // Pads
   input wire logic [7:0] i_pc_pu_wdata, o_port_c_pullup_reg, o_port_e_pullup_reg // Regs
);
   default clocking dc @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_reset_state: assert property ($rose(i_rst_n) |-> o_pad_pu == 6'h3f && o_pad_oe_n == 6'h3f)
      else $error("reset state wrong");
   a_pc_write: assert property (i_pc_pu_we |-> ##2 o_port_c_pullup_reg == $past(i_pc_pu_wdata, 2))
      else $error("pull-up write lost");
   a_pu_map: assert property (o_pad_pu == {o_port_e_pullup_reg[7:4], o_port_c_pullup_reg[7:6]})
      else $error("pull-up bit map wrong");
   a_timer_route: assert property (i_idx_func == 2'h1 |-> ##2 o_pad_oe_n[0] == !$past(i_timer_oe[0])
      && o_timer_in[0] == $past(i_pad[0]))
      else $error("timer route wrong");
   a_home_port: assert property (i_home_func == 2'h2 |-> ##2 o_pad_oe_n[1] == !$past(i_gpio_dir[1])
      && (o_pad_oe_n[1] || o_pad[1] == $past(i_gpio_out[1])))
      else $error("home port wrong");
   a_master_drive: assert property (i_spi_gpio[1:0] == 2'h0 ##1 i_spi_master |=> o_pad_oe_n[3:2]
      == 2'h0 && o_pad[3:2] == {$past(i_spi_mosi_out), $past(i_spi_sclk_out)})
      else $error("master drive wrong");
   a_miso_release: assert property (!i_spi_gpio[2] ##1 (i_spi_master || i_pad[5]) |=> o_pad_oe_n[4])
      else $error("master-in not released");
   a_slave_select: assert property (i_spi_gpio[3:2] == 2'h0 ##1 (!i_spi_master && !i_pad[5])
      |=> o_spi_selected && !o_pad_oe_n[4])
      else $error("slave select wrong");
   c_selected: cover property (o_spi_selected);
   c_pc_write: cover property (i_pc_pu_we);
   c_timer: cover property (i_idx_func == 2'h1);
endmodule : dspfs_asserts

bind dspfs_top dspfs_asserts i_dspfs_asserts (.*);

// File: testbench/dspfs_peer.sv
// Partner: far-side drivers and pad wire resolution
`timescale 1ns/1ps
module dspfs_peer
(
   input  wire logic       i_clk,      // Clock for the float pattern
   input  wire logic [5:0] i_ext_oe,   // Far side drives pin
   input  wire logic [5:0] i_ext_val,  // Far-side level
   input  wire logic [5:0] i_dev,      // Device pad out
   input  wire logic [5:0] i_dev_oe_n, // Device drive, low drives
   input  wire logic [5:0] i_dev_pu,   // Device pull-up
   output logic      [5:0] o_level     // Resolved pad levels
);
   logic flip = 1'b0;
   // Unpulled loose pins toggle so no stale level survives
   always_ff @(posedge i_clk) flip <= !flip;
   // Device drive wins; far side acts as SPI peer, select source and sensor
   always_comb
      for (int k = 0; k < 6; k++)
         o_level[k] = !i_dev_oe_n[k] ? i_dev[k] : i_ext_oe[k] ? i_ext_val[k] : i_dev_pu[k] | flip;
endmodule : dspfs_peer

// File: testbench/dspfs_top_test.sv
// Testbench: reset, pull-up, pin routing and SPI pin scenarios
`timescale 1ns/1ps
module dspfs_top_test;
   typedef struct {int k; logic [7:0] m; logic [7:0] e;} dspfs_note_s;
   dspfs_note_s q[$];
   int          num_errors = 0, compares = 0;
   logic        i_clk = 1'b0, i_rst_n = 1'b0, i_pc_pu_we = 1'b0, i_pe_pu_we = 1'b0;
   logic        i_spi_master = 1'b0, i_spi_sclk_out = 1'b0, i_spi_mosi_out = 1'b0;
   logic        i_spi_miso_out = 1'b0, o_quad0_index_in, o_quad0_home_in, o_spi_sclk_in;
   logic        o_spi_mosi_in, o_spi_miso_in, o_spi_selected;
   logic [1:0]  i_idx_func = 2'h0, i_home_func = 2'h0, i_timer_out = 2'h0, i_timer_oe = 2'h0;
   logic [1:0]  o_timer_in;
   logic [3:0]  i_spi_gpio = 4'h0;
   logic [5:0]  i_gpio_dir = 6'h0, i_gpio_out = 6'h0, ext = 6'h2a, i_pad, o_pad, o_pad_oe_n;
   logic [5:0]  o_pad_pu, o_gpio_in, lv, dr, dv;
   logic [7:0]  i_pc_pu_wdata = 8'h0, i_pe_pu_wdata = 8'h0, o_port_c_pullup_reg;
   logic [7:0]  o_port_e_pullup_reg, ob[7];
   logic [15:0] hst[10];
   string       nm[7] = '{"c_pu", "e_pu", "pad_pu", "oe_n", "pad", "periph", "gpio_in"};
   always #2.5 i_clk = !i_clk;
   dspfs_top  i_dspfs_top (.*);
   dspfs_peer i_dspfs_peer (.i_clk, .i_ext_oe(6'h3f), .i_ext_val(ext), .i_dev(o_pad),
                            .i_dev_oe_n(o_pad_oe_n), .i_dev_pu(o_pad_pu), .o_level(i_pad));
   // Observed outputs by note index
   always_comb ob = '{o_port_c_pullup_reg, o_port_e_pullup_reg, {2'h0, o_pad_pu}, {2'h0, o_pad_oe_n},
      {2'h0, o_pad}, {o_spi_selected, o_spi_miso_in, o_spi_mosi_in, o_spi_sclk_in, o_timer_in,
      o_quad0_home_in, o_quad0_index_in}, {2'h0, o_gpio_in}};
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick
   task automatic note(input int k, input logic [7:0] m, input logic [7:0] e);
      q.push_back('{k, m, e});
   endtask : note
   task automatic results();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results
   // Oldest notes against the settled outputs, after the driver's edge
   always @(negedge i_clk)
   begin
      #1;
      while (q.size() > 0)
      begin
         compares++;
         if ((ob[q[0].k] & q[0].m) !== (q[0].e & q[0].m))
         begin
            num_errors++;
            $display("wrong value %s exp %h got %h", nm[q[0].k], q[0].e & q[0].m, ob[q[0].k] & q[0].m);
         end
         void'(q.pop_front());
      end
   end
   // Watchdog well past the run length
   initial
   begin
      #20000;
      num_errors++;
      results();
   end
   initial
   begin
      void'($urandom(56885));
      tick(1);
      note(0, 8'hff, 8'hff);
      note(3, 8'h3f, 8'h3f);
      tick(4);
      i_rst_n = 1'b1;
      tick(3);
      note(5, 8'hb3, 8'h22);
      $display("reset test done");
      for (int n = 0; n < 10; n++)
      begin
         if (n >= 2)
         begin
            note(0, 8'hff, hst[n-2][15:8]);
            note(1, 8'hff, hst[n-2][7:0]);
            note(2, 8'h3f, {2'h0, hst[n-2][7:4], hst[n-2][15:14]});
         end
         hst[n] = n < 6 ? 16'($urandom) : 16'hffff;
         {i_pc_pu_wdata, i_pe_pu_wdata} = hst[n];
         i_pc_pu_we = n < 8;
         i_pe_pu_we = n < 8;
         tick(1);
      end
      $display("pull-up test done");
      for (int f = 0; f < 4; f++)
      begin
         {i_gpio_dir, i_gpio_out, i_timer_out, i_timer_oe, ext} = 22'($urandom);
         i_idx_func = 2'(f);
         i_home_func = 2'(f);
         tick(3);
         dr = {4'h0, f == 1 ? i_timer_oe : f == 2 ? i_gpio_dir[1:0] : 2'h0};
         dv = {4'h0, f == 1 ? i_timer_out : i_gpio_out[1:0]};
         lv = dr & dv | ~dr & ext;
         note(3, 8'h03, {2'h0, ~dr});
         note(4, {2'h0, dr}, {2'h0, dv});
         note(5, 8'h0f, {4'h0, f == 1 ? lv[1:0] : 2'h3, f[0] ^ f[1] ? 2'h3 : lv[1:0]});
         note(6, 8'h03, {2'h0, lv});
      end
      $display("decoder pin test done");
      for (int i = 0; i < 8; i++)
      begin
         {i_gpio_dir, i_gpio_out, i_spi_sclk_out, i_spi_mosi_out, i_spi_miso_out, ext} = 21'($urandom);
         ext[5] = i[1];
         i_spi_master = i[0];
         i_spi_gpio = i[2] ? 4'hf : 4'h0;
         tick(3);
         dv = i[2] ? i_gpio_out : {1'b0, i_spi_miso_out, i_spi_mosi_out, i_spi_sclk_out, 2'h0};
         dr = i[2] ? i_gpio_dir : {1'b0, !i[0] && !i[1], i[0], i[0], 2'h0};
         lv = dr & dv | ~dr & ext;
         note(3, 8'h3c, {2'h0, ~dr});
         note(4, {2'h0, dr & 6'h3c}, {2'h0, dv});
         note(6, 8'h3c, {2'h0, lv});
         note(5, i[2] ? 8'hf0 : i[0] ? 8'hc0 : 8'hb0, i[2] ? 8'h70 : {!i[0] && !i[1], lv[4:2], 4'h0});
      end
      $display("spi pin test done");
      tick(2);
      results();
   end
endmodule : dspfs_top_test
